//--- hdl/qcr_pkg.sv
// package for the quadrature correction register group
// assumes an 8-bit register port and one converter clock
`default_nettype none

package qcr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] QCR_ADDR_GAIN_A_LOW   = 8'h1b;
  localparam logic [7:0] QCR_ADDR_GAIN_B_LOW   = 8'h1c;
  localparam logic [7:0] QCR_ADDR_PHASE_LOW    = 8'h1d;
  localparam logic [7:0] QCR_ADDR_UPPER_BITS   = 8'h1e;
  localparam logic [7:0] QCR_ADDR_STATUS       = 8'h1f;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] QCR_RST_GAIN_A_LOW    = 8'h00;
  localparam logic [7:0] QCR_RST_GAIN_B_LOW    = 8'h00;
  localparam logic [7:0] QCR_RST_PHASE_LOW     = 8'h00;
  localparam logic [7:0] QCR_RST_UPPER_BITS    = 8'h24;
  localparam int         QCR_UP_PHASE_MSB      = 7;
  localparam int         QCR_UP_PHASE_LSB      = 6;
  localparam int         QCR_UP_GAIN_A_MSB     = 5;
  localparam int         QCR_UP_GAIN_A_LSB     = 3;
  localparam int         QCR_UP_GAIN_B_MSB     = 2;
  localparam int         QCR_UP_GAIN_B_LSB     = 0;
  localparam int         QCR_ST_CLK_ALARM      = 7;
  localparam int         QCR_ST_TX_OFF         = 6;
  localparam int         QCR_GAIN_FRAC         = 10;
  localparam int         QCR_PHASE_FRAC        = 12;
  // version value is arbitrary
  localparam logic [5:0] QCR_VERSION           = 6'h2a;
  localparam logic [10:0] QCR_RST_GAIN_ACTIVE  = 11'h400;
  localparam logic [9:0]  QCR_RST_PHASE_ACTIVE = 10'h000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [2:0] QCR_CLK_LOSS_CYCLES   = 3'h4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } qcr_reg_req_s;

  typedef struct packed {
    logic [10:0] gain_a;
    logic [10:0] gain_b;
    logic [9:0]  phase;
  } qcr_corr_s;

endpackage

`default_nettype wire

//--- hdl/qcr_regs.sv
// quadrature correction registers, shadow load and gain/phase datapath
// assumes register port and input_data_clock level come from the serial
// interface logic and the pin; samples are on sys_clk
`timescale 1ns/100ps
`default_nettype none

module qcr_regs #(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire qcr_pkg::qcr_reg_req_s reg_req,
  output var  logic [7:0]            reg_rdata,
  output var  logic                  reg_rvalid,
  input  wire logic                  input_data_clock,
  input  wire logic                  sample_valid,
  input  wire logic [SAMPLE_W-1:0]   sample_i,
  input  wire logic [SAMPLE_W-1:0]   sample_q,
  output var  logic [SAMPLE_W-1:0]   dac_a_out,
  output var  logic [SAMPLE_W-1:0]   dac_b_out,
  output var  logic                  dac_out_valid,
  output var  logic                  clk_alarm,
  output var  logic                  tx_off
);
  import qcr_pkg::*;

  localparam int PROD_W = SAMPLE_W + 12;

  // ----------------------------------------------------------------
  // staged registers
  // ----------------------------------------------------------------
  logic [7:0]  gain_a_low_q;
  logic [7:0]  gain_b_low_q;
  logic [7:0]  phase_low_q;
  logic [7:0]  upper_bits_q;
  logic        autosync_q;
  logic        wr_gain_a;

  assign wr_gain_a = reg_req.wr_en && (reg_req.addr == QCR_ADDR_GAIN_A_LOW);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_a_low_q <= QCR_RST_GAIN_A_LOW;
    end else if (wr_gain_a) begin
      gain_a_low_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_b_low_q <= QCR_RST_GAIN_B_LOW;
      phase_low_q  <= QCR_RST_PHASE_LOW;
      upper_bits_q <= QCR_RST_UPPER_BITS;
    end else if (reg_req.wr_en) begin
      if (reg_req.addr == QCR_ADDR_GAIN_B_LOW) begin
        gain_b_low_q <= reg_req.wdata;
      end
      if (reg_req.addr == QCR_ADDR_PHASE_LOW) begin
        phase_low_q <= reg_req.wdata;
      end
      if (reg_req.addr == QCR_ADDR_UPPER_BITS) begin
        upper_bits_q <= reg_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // autosync into active settings
  // ----------------------------------------------------------------
  // one cycle late so the new low byte is already staged
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      autosync_q <= 1'b0;
    end else begin
      autosync_q <= wr_gain_a;
    end
  end

  qcr_corr_s active_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q.gain_a <= QCR_RST_GAIN_ACTIVE;
      active_q.gain_b <= QCR_RST_GAIN_ACTIVE;
      active_q.phase  <= QCR_RST_PHASE_ACTIVE;
    end else if (autosync_q) begin
      active_q.gain_a <= {upper_bits_q[QCR_UP_GAIN_A_MSB:QCR_UP_GAIN_A_LSB], gain_a_low_q};
      active_q.gain_b <= {upper_bits_q[QCR_UP_GAIN_B_MSB:QCR_UP_GAIN_B_LSB], gain_b_low_q};
      active_q.phase  <= {upper_bits_q[QCR_UP_PHASE_MSB:QCR_UP_PHASE_LSB], phase_low_q};
    end
  end

  // ----------------------------------------------------------------
  // data clock loss detection
  // ----------------------------------------------------------------
  logic       dclk_meta_q;
  logic       dclk_sync_q;
  logic       dclk_prev_q;
  logic [2:0] loss_cnt_q;
  logic       loss_hit;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dclk_meta_q <= 1'b0;
      dclk_sync_q <= 1'b0;
      dclk_prev_q <= 1'b0;
    end else begin
      dclk_meta_q <= input_data_clock;
      dclk_sync_q <= dclk_meta_q;
      dclk_prev_q <= dclk_sync_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loss_cnt_q <= 3'h0;
    end else if (dclk_sync_q != dclk_prev_q) begin
      loss_cnt_q <= 3'h0;
    end else if (loss_cnt_q != QCR_CLK_LOSS_CYCLES) begin
      loss_cnt_q <= loss_cnt_q + 3'h1;
    end
  end

  assign loss_hit = (loss_cnt_q == QCR_CLK_LOSS_CYCLES);

  // ----------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------
  logic wr_status;

  assign wr_status = reg_req.wr_en && (reg_req.addr == QCR_ADDR_STATUS);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_alarm <= 1'b0;
    end else if (loss_hit) begin
      clk_alarm <= 1'b1;
    end else if (wr_status && !reg_req.wdata[QCR_ST_CLK_ALARM]) begin
      clk_alarm <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_off <= 1'b0;
    end else if (loss_hit) begin
      tx_off <= 1'b1;
    end else if (wr_status && !reg_req.wdata[QCR_ST_TX_OFF]) begin
      tx_off <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;

  always_comb begin
    case (reg_req.addr)
      QCR_ADDR_GAIN_A_LOW: rdata_d = gain_a_low_q;
      QCR_ADDR_GAIN_B_LOW: rdata_d = gain_b_low_q;
      QCR_ADDR_PHASE_LOW:  rdata_d = phase_low_q;
      QCR_ADDR_UPPER_BITS: rdata_d = upper_bits_q;
      QCR_ADDR_STATUS:     rdata_d = {clk_alarm, tx_off, QCR_VERSION};
      default:             rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd_en;
      if (reg_req.rd_en) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // correction datapath
  // ----------------------------------------------------------------
  logic signed [PROD_W-1:0]   phase_prod;
  logic signed [PROD_W-1:0]   i_sum;
  logic signed [SAMPLE_W-1:0] i_corr;
  logic signed [SAMPLE_W+12:0] a_prod;
  logic signed [SAMPLE_W+12:0] b_prod;
  logic [SAMPLE_W-1:0]        a_sat;
  logic [SAMPLE_W-1:0]        b_sat;

  // saturate signed value to SAMPLE_W bits
  function automatic logic [SAMPLE_W-1:0] sat(input logic signed [SAMPLE_W+12:0] v);
    logic signed [SAMPLE_W+12:0] hi;
    logic signed [SAMPLE_W+12:0] lo;
    hi = (SAMPLE_W+13)'(2 ** (SAMPLE_W - 1) - 1);
    lo = -hi - (SAMPLE_W+13)'(1);
    if (v > hi) begin
      sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end else if (v < lo) begin
      sat = {1'b1, {(SAMPLE_W-1){1'b0}}};
    end else begin
      sat = v[SAMPLE_W-1:0];
    end
  endfunction

  always_comb begin
    phase_prod = PROD_W'($signed(sample_q) * $signed(active_q.phase));
    i_sum      = PROD_W'($signed(sample_i)) + (phase_prod >>> QCR_PHASE_FRAC);
    i_corr     = sat((SAMPLE_W+13)'(i_sum));
  end

  always_comb begin
    a_prod = (SAMPLE_W+13)'(($signed(i_corr) * $signed({1'b0, active_q.gain_a}))
             >>> QCR_GAIN_FRAC);
    b_prod = (SAMPLE_W+13)'(($signed(sample_q) * $signed({1'b0, active_q.gain_b}))
             >>> QCR_GAIN_FRAC);
    a_sat  = sat(a_prod);
    b_sat  = sat(b_prod);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_a_out     <= '0;
      dac_b_out     <= '0;
      dac_out_valid <= 1'b0;
    end else begin
      dac_out_valid <= sample_valid;
      if (tx_off) begin
        dac_a_out <= '0;
        dac_b_out <= '0;
      end else if (sample_valid) begin
        dac_a_out <= a_sat;
        dac_b_out <= b_sat;
      end
    end
  end

endmodule

`default_nettype wire

//--- sim/qcr_regs_props.sv
// concurrent checks on the quadrature correction register ports
// assumes it is bound onto qcr_regs, one clock domain
`timescale 1ns/100ps
`default_nettype none

module qcr_regs_props #(
  parameter int SAMPLE_W = 16
) (
  input wire logic                  sys_clk,
  input wire logic                  reset_n,
  input wire qcr_pkg::qcr_reg_req_s reg_req,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  reg_rvalid,
  input wire logic                  input_data_clock,
  input wire logic                  sample_valid,
  input wire logic [SAMPLE_W-1:0]   sample_i,
  input wire logic [SAMPLE_W-1:0]   sample_q,
  input wire logic [SAMPLE_W-1:0]   dac_a_out,
  input wire logic [SAMPLE_W-1:0]   dac_b_out,
  input wire logic                  dac_out_valid,
  input wire logic                  clk_alarm,
  input wire logic                  tx_off
);
  import qcr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire st_wr = reg_req.wr_en && reg_req.addr == QCR_ADDR_STATUS;

  version_read_a: assert property (reg_req.rd_en && reg_req.addr == QCR_ADDR_STATUS
    |=> reg_rvalid && reg_rdata[5:0] == QCR_VERSION) else $error("version field wrong");
  alarm_keep_a: assert property (clk_alarm && !(st_wr && !reg_req.wdata[7])
    |=> clk_alarm) else $error("alarm dropped without clear");
  txoff_keep_a: assert property (tx_off && !(st_wr && !reg_req.wdata[6])
    |=> tx_off) else $error("tx off dropped without clear");
  txoff_mute_a: assert property (tx_off |=> dac_a_out == '0 && dac_b_out == '0)
    else $error("outputs not muted");
  alarm_pair_a: assert property ($rose(clk_alarm) |-> tx_off)
    else $error("alarm without tx off");
  loss_set_a: assert property ($stable(input_data_clock) [*8] |-> ##[0:4] clk_alarm)
    else $error("alarm missing on stopped clock");
  loss_restart_a: assert property ($changed(input_data_clock) |-> ##5 !$rose(clk_alarm))
    else $error("alarm despite data clock edge");
  valid_follow_a: assert property (dac_out_valid == $past(sample_valid))
    else $error("output valid not one cycle late");
endmodule

bind qcr_regs qcr_regs_props #(.SAMPLE_W(SAMPLE_W)) u_props (
  .sys_clk          (sys_clk),
  .reset_n          (reset_n),
  .reg_req          (reg_req),
  .reg_rdata        (reg_rdata),
  .reg_rvalid       (reg_rvalid),
  .input_data_clock (input_data_clock),
  .sample_valid     (sample_valid),
  .sample_i         (sample_i),
  .sample_q         (sample_q),
  .dac_a_out        (dac_a_out),
  .dac_b_out        (dac_b_out),
  .dac_out_valid    (dac_out_valid),
  .clk_alarm        (clk_alarm),
  .tx_off           (tx_off)
);

`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the quadrature correction registers
// assumes qcr_regs and its checker are compiled first
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import qcr_pkg::*;
  // starts low so no stray falling edge at time zero
  logic         sys_clk = 1'b0;
  logic         reset_n, dclk, run, svalid, rvalid, ovalid, alarm, txoff;
  qcr_reg_req_s req;
  logic [15:0]  si, sq, dac_a, dac_b;
  logic [7:0]   rdata;
  int           num_errors, comparisons;

  qcr_regs uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .input_data_clock(dclk), .sample_valid(svalid), .sample_i(si),
    .sample_q(sq), .dac_a_out(dac_a), .dac_b_out(dac_b), .dac_out_valid(ovalid),
    .clk_alarm(alarm), .tx_off(txoff));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // data clock only runs while run is set
  always @(negedge sys_clk) if (run) dclk <= ~dclk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    req.wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    req.rd_en = 1'b0;
    chk({15'h0000, rvalid}, 16'h0001);
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic smp(input logic [15:0] i, q, ea, eb);
    @(negedge sys_clk);
    svalid = 1'b1;
    si = i;
    sq = q;
    @(negedge sys_clk);
    svalid = 1'b0;
    chk({15'h0000, ovalid}, 16'h0001);
    chk(dac_a, ea);
    chk(dac_b, eb);
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    {reset_n, svalid, dclk, si, sq, req} = '0;
    run = 1'b1;
    num_errors = 0;
    comparisons = 0;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    rd(QCR_ADDR_GAIN_A_LOW, 8'h00);
    rd(QCR_ADDR_GAIN_B_LOW, 8'h00);
    rd(QCR_ADDR_PHASE_LOW, 8'h00);
    rd(QCR_ADDR_UPPER_BITS, 8'h24);
    rd(8'h20, 8'h00);
    wr(QCR_ADDR_STATUS, 8'hff);
    rd(QCR_ADDR_STATUS, {2'b00, QCR_VERSION});
    smp(16'h1000, 16'h0800, 16'h1000, 16'h0800);
    // gain a half, gain b quarter, phase -64
    wr(QCR_ADDR_GAIN_B_LOW, 8'h00);
    wr(QCR_ADDR_PHASE_LOW, 8'hc0);
    wr(QCR_ADDR_UPPER_BITS, 8'hd1);
    rd(QCR_ADDR_UPPER_BITS, 8'hd1);
    smp(16'h1000, 16'h0800, 16'h1000, 16'h0800);
    wr(QCR_ADDR_GAIN_A_LOW, 8'h00);
    repeat (2) @(negedge sys_clk);
    smp(16'h1000, 16'h0800, 16'h07f0, 16'h0200);
    run = 1'b0;
    // bounded wait; a missing alarm counts and skips to the report
    for (int n = 0; n < 20 && alarm !== 1'b1; n++) @(negedge sys_clk);
    chk({15'h0000, alarm}, 16'h0001);
    if (alarm === 1'b1) begin
      chk({15'h0000, txoff}, 16'h0001);
      rd(QCR_ADDR_STATUS, {2'b11, QCR_VERSION});
      smp(16'h1000, 16'h0800, 16'h0000, 16'h0000);
      // clearing while still stopped must not stick
      wr(QCR_ADDR_STATUS, 8'h00);
      rd(QCR_ADDR_STATUS, {2'b11, QCR_VERSION});
      run = 1'b1;
      repeat (6) @(negedge sys_clk);
      wr(QCR_ADDR_STATUS, 8'h00);
      rd(QCR_ADDR_STATUS, {2'b00, QCR_VERSION});
      smp(16'h1000, 16'h0800, 16'h07f0, 16'h0200);
    end
    close_out();
  end
endmodule

`default_nettype wire
